/* File: src/rqhrp_pkg.sv */
`default_nettype none
package rqhrp_pkg;
    // ------------------------------------------------
    // Device register offsets
    // ------------------------------------------------
    localparam logic [11:0] RC1_OFS = 12'h174;
    localparam logic [11:0] RC2_OFS = 12'h176;
    localparam logic [11:0] HSTS_OFS = 12'h17C;
    localparam logic [11:0] HLEN_OFS = 12'h17E;
    localparam logic [11:0] QC_OFS = 12'h182;
    localparam logic [11:0] DP_OFS = 12'h186;
    localparam logic [11:0] DTT_OFS = 12'h18C;
    localparam logic [11:0] DBT_OFS = 12'h18E;
    localparam logic [11:0] IER_OFS = 12'h190;
    localparam logic [11:0] ISR_OFS = 12'h192;
    localparam logic [11:0] FCT_OFS = 12'h19C;
    localparam logic [11:0] FC_OFS = 12'h1B8;
    localparam logic [11:0] DATA_OFS = 12'h1C0;
    // ------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------
    localparam int RC1_FLOW = 10;
    localparam int RC1_BLOCK = 0;
    localparam int RC2_CSUM_LSB = 0;
    localparam int QC_START = 3;
    localparam int QC_AUTO = 4;
    localparam int QC_FEN = 5;
    localparam int QC_BEN = 6;
    localparam int QC_DEN = 7;
    localparam int QC_IPOFS = 9;
    localparam int QC_FST = 10;
    localparam int QC_BST = 11;
    localparam int QC_DST = 12;
    localparam logic [15:0] QC_WMASK = 16'h02F8;
    localparam int DP_AUTO = 14;
    localparam logic [15:0] DP_WMASK = 16'h47FF;
    localparam int IER_RX = 13;
    localparam int ISR_RX = 13;
    localparam logic [15:0] RST16 = 16'h0000;
    // ------------------------------------------------
    // Buffer sizing and timing
    // ------------------------------------------------
    localparam int MEM_AW = 11;
    localparam logic [11:0] MEM_DEPTH = 12'h800;
    localparam logic [11:0] MAX_FRAME_WORDS = 12'h3EC;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam logic [6:0] US_CYC = 7'(US_NS / CLK_PERIOD_NS);
    // ------------------------------------------------
    // Host command registers
    // ------------------------------------------------
    localparam logic [7:0] H_CMD_OFS = 8'h00;
    localparam logic [7:0] H_WDATA_OFS = 8'h04;
    localparam logic [7:0] H_RDATA_OFS = 8'h08;
    localparam logic [7:0] H_STAT_OFS = 8'h0C;
    localparam int CMD_WR_BIT = 12;
    localparam int CMD_BYTE_BIT = 13;

    // Words taken by one stored frame, kept double-word aligned
    function automatic logic [11:0] frame_words(input logic [11:0] len, input logic off);
        logic [11:0] w;
        w = 12'h002 + {11'h000, off} + ((len + 12'h001) >> 1);
        return (w + 12'h001) & 12'hFFE;
    endfunction
endpackage
`default_nettype wire

/* File: src/rqhrp_if.sv */
`default_nettype none
interface rqhrp_if;
    logic sel;
    logic wr;
    logic byte_mode;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic ack;
    logic irq_n;
    modport dev (
        input sel, wr, byte_mode, addr, wdata,
        output rdata, ack, irq_n
    );
    modport host (
        output sel, wr, byte_mode, addr, wdata,
        input rdata, ack, irq_n
    );
endinterface
`default_nettype wire

/* File: src/rqhrp_dev.sv */
// Added by the designer: the host bus interface to the registers.
`default_nettype none
// Contract
// - Control one: flow control, block mode enables
// - Control two: per-protocol checksum check enables
// - Current frame status in read-only register
// - Current frame byte count, 12 bits
// - Start-access bit gates data port access
// - Auto de-queue releases frames read out
// - Frame count over threshold raises interrupt
// - Byte count over threshold raises interrupt
// - Residence over microsecond threshold raises interrupt
// - IP offset bit inserts two bytes
// - Auto-increment advances data pointer
// - Interrupt forwarded only when enabled
// - Status bits clear on write one
// - Upper byte holds frame count at interrupt
// - First data read of burst is dummy
// - Host reads to double-word boundary
// - Clearing interrupt refreshes frame count
// - Frame count read loads first header
// - Reading both headers loads next header
// - Frame stored as status, count, data
module rqhrp_dev (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Host bus
    rqhrp_if.dev BUS,
    // Frame input
    input wire logic RX_SOF_I,
    input wire logic [15:0] RX_STS_I,
    input wire logic [11:0] RX_LEN_I,
    input wire logic RX_DAT_VLD_I,
    input wire logic [15:0] RX_DAT_I,
    input wire logic RX_EOF_I,
    output logic RX_RDY_O,
    // Receive controls
    output logic RX_FLOW_EN_O,
    output logic RX_BLOCK_O,
    output logic [3:0] RX_CSUM_EN_O
);
    typedef struct packed {
        logic [15:0] rc1;
        logic [15:0] rc2;
        logic [15:0] qc;
        logic [15:0] dp;
        logic [15:0] dtt;
        logic [15:0] dbt;
        logic [15:0] interrupt_enable;
        logic [15:0] interrupt_status;
        logic [15:0] hsts;
        logic [15:0] rdata;
        logic [15:0] bytes;
        logic [15:0] age;
        logic [11:0] hlen;
        logic [11:0] head;
        logic [11:0] hptr;
        logic [11:0] tail;
        logic [11:0] wp;
        logic [11:0] flen;
        logic [7:0] frames;
        logic [7:0] snap;
        logic [7:0] fct;
        logic [6:0] usdiv;
        logic hs_rd;
        logic hl_rd;
        logic any;
        logic first;
        logic ack;
        logic off;
    } rqhrp_dev_type;

    rqhrp_dev_type r_q;
    rqhrp_dev_type r_d;
    logic [15:0] mem [0:2**rqhrp_pkg::MEM_AW-1];
    logic we;
    logic [11:0] wa;
    logic [15:0] wd;

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb
    begin
        logic take;
        logic arrive;
        logic rel;
        logic [11:0] rlen;
        logic [11:0] nx;
        logic [11:0] da;
        logic [15:0] w;
        logic [10:0] step;
        logic fx;
        logic bx;
        logic dx;
        r_d = r_q;
        we = 1'b0;
        wa = r_q.tail;
        wd = RX_STS_I;
        take = BUS.sel & ~r_q.ack;
        arrive = 1'b0;
        rel = 1'b0;
        rlen = mem[11'(r_q.head + 12'h001)][11:0];
        nx = r_q.hptr + rqhrp_pkg::frame_words(r_q.hlen, r_q.qc[rqhrp_pkg::QC_IPOFS]);
        da = r_q.head + {2'h0, r_q.dp[10:1]};
        w = mem[da[rqhrp_pkg::MEM_AW-1:0]];
        step = BUS.byte_mode ? 11'h001 : 11'h002;
        r_d.ack = take;
        // Frame intake
        if (RX_SOF_I)
        begin
            we = 1'b1;
            r_d.flen = RX_LEN_I;
            r_d.off = r_q.qc[rqhrp_pkg::QC_IPOFS];
            r_d.wp = r_q.tail + 12'h002 + {11'h000, r_q.qc[rqhrp_pkg::QC_IPOFS]};
        end
        else if (RX_DAT_VLD_I)
        begin
            we = 1'b1;
            wa = r_q.wp;
            wd = RX_DAT_I;
            r_d.wp = r_q.wp + 12'h001;
        end
        else if (RX_EOF_I)
        begin
            we = 1'b1;
            wa = r_q.tail + 12'h001;
            wd = {4'h0, r_q.flen};
            r_d.tail = r_q.tail + rqhrp_pkg::frame_words(r_q.flen, r_q.off);
            arrive = 1'b1;
        end
        // Register access
        if (take && BUS.wr)
        begin
            unique case (BUS.addr)
                rqhrp_pkg::RC1_OFS: r_d.rc1 = BUS.wdata;
                rqhrp_pkg::RC2_OFS: r_d.rc2 = BUS.wdata;
                rqhrp_pkg::QC_OFS:
                begin
                    r_d.qc = BUS.wdata & rqhrp_pkg::QC_WMASK;
                    if (BUS.wdata[rqhrp_pkg::QC_START] && !r_q.qc[rqhrp_pkg::QC_START])
                        r_d.first = 1'b1;
                    rel = r_q.qc[rqhrp_pkg::QC_START] & ~BUS.wdata[rqhrp_pkg::QC_START]
                        & r_q.qc[rqhrp_pkg::QC_AUTO] & (r_q.frames != 8'h00);
                end
                rqhrp_pkg::DP_OFS: r_d.dp = BUS.wdata & rqhrp_pkg::DP_WMASK;
                rqhrp_pkg::DTT_OFS: r_d.dtt = BUS.wdata;
                rqhrp_pkg::DBT_OFS: r_d.dbt = BUS.wdata;
                rqhrp_pkg::IER_OFS: r_d.interrupt_enable = BUS.wdata;
                rqhrp_pkg::ISR_OFS:
                begin
                    r_d.interrupt_status = r_q.interrupt_status & ~BUS.wdata;
                    if (BUS.wdata[rqhrp_pkg::ISR_RX])
                        r_d.snap = r_q.frames;
                end
                rqhrp_pkg::FCT_OFS: r_d.fct = BUS.wdata[7:0];
                default: ;
            endcase
        end
        else if (take)
        begin
            r_d.rdata = rqhrp_pkg::RST16;
            unique case (BUS.addr)
                rqhrp_pkg::RC1_OFS: r_d.rdata = r_q.rc1;
                rqhrp_pkg::RC2_OFS: r_d.rdata = r_q.rc2;
                rqhrp_pkg::HSTS_OFS:
                begin
                    r_d.rdata = r_q.hsts;
                    r_d.hs_rd = 1'b1;
                end
                rqhrp_pkg::HLEN_OFS:
                begin
                    r_d.rdata = {4'h0, r_q.hlen};
                    r_d.hl_rd = 1'b1;
                end
                rqhrp_pkg::QC_OFS: r_d.rdata = r_q.qc;
                rqhrp_pkg::DP_OFS: r_d.rdata = r_q.dp;
                rqhrp_pkg::DTT_OFS: r_d.rdata = r_q.dtt;
                rqhrp_pkg::DBT_OFS: r_d.rdata = r_q.dbt;
                rqhrp_pkg::IER_OFS: r_d.rdata = r_q.interrupt_enable;
                rqhrp_pkg::ISR_OFS: r_d.rdata = r_q.interrupt_status;
                rqhrp_pkg::FCT_OFS: r_d.rdata = {8'h00, r_q.fct};
                rqhrp_pkg::FC_OFS:
                begin
                    r_d.rdata = {r_q.snap, 8'h00};
                    r_d.hptr = r_q.head;
                    r_d.hs_rd = 1'b0;
                    r_d.hl_rd = 1'b0;
                end
                rqhrp_pkg::DATA_OFS:
                begin
                    if (!r_q.qc[rqhrp_pkg::QC_START])
                        r_d.rdata = rqhrp_pkg::RST16;
                    else if (r_q.first)
                        r_d.first = 1'b0;
                    else
                    begin
                        r_d.rdata = BUS.byte_mode ?
                            {8'h00, (r_q.dp[0] ? w[15:8] : w[7:0])} : w;
                        if (r_q.dp[rqhrp_pkg::DP_AUTO])
                            r_d.dp[10:0] = r_q.dp[10:0] + step;
                    end
                end
                default: ;
            endcase
            if ((r_d.hs_rd && r_d.hl_rd) && BUS.addr != rqhrp_pkg::FC_OFS)
            begin
                r_d.hptr = nx;
                r_d.hs_rd = 1'b0;
                r_d.hl_rd = 1'b0;
            end
        end
        // Header registers follow the selected frame
        r_d.hsts = mem[r_d.hptr[rqhrp_pkg::MEM_AW-1:0]];
        r_d.hlen = mem[11'(r_d.hptr + 12'h001)][11:0];
        // Queue accounting
        if (rel)
        begin
            r_d.head = r_q.head + rqhrp_pkg::frame_words(rlen, r_q.qc[rqhrp_pkg::QC_IPOFS]);
            r_d.dp[10:0] = 11'h000;
        end
        r_d.frames = r_q.frames + {7'h00, arrive} - {7'h00, rel};
        r_d.bytes = r_q.bytes + (arrive ? {4'h0, r_q.flen} : 16'h0000)
            - (rel ? {4'h0, rlen} : 16'h0000);
        // Residence time in microsecond steps
        r_d.usdiv = (r_q.usdiv == rqhrp_pkg::US_CYC - 7'h01) ? 7'h00 : r_q.usdiv + 7'h01;
        if (rel || r_q.frames == 8'h00)
            r_d.age = 16'h0000;
        else if (r_q.usdiv == rqhrp_pkg::US_CYC - 7'h01 && r_q.age != 16'hFFFF)
            r_d.age = r_q.age + 16'h0001;
        // Thresholds
        fx = r_q.qc[rqhrp_pkg::QC_FEN] & (r_q.frames > r_q.fct);
        bx = r_q.qc[rqhrp_pkg::QC_BEN] & (r_q.bytes > r_q.dbt);
        dx = r_q.qc[rqhrp_pkg::QC_DEN] & (r_q.age > r_q.dtt);
        r_d.qc[rqhrp_pkg::QC_FST] = fx;
        r_d.qc[rqhrp_pkg::QC_BST] = bx;
        r_d.qc[rqhrp_pkg::QC_DST] = dx;
        r_d.any = fx | bx | dx;
        if (r_d.any && !r_q.any)
        begin
            r_d.interrupt_status[rqhrp_pkg::ISR_RX] = 1'b1;
            r_d.snap = r_q.frames;
        end
    end

    // ------------------------------------------------
    // Registers and buffer
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (we)
            mem[wa[rqhrp_pkg::MEM_AW-1:0]] <= wd;
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign RX_RDY_O = 12'(r_q.tail - r_q.head)
        <= 12'(rqhrp_pkg::MEM_DEPTH - rqhrp_pkg::MAX_FRAME_WORDS);
    assign RX_FLOW_EN_O = r_q.rc1[rqhrp_pkg::RC1_FLOW];
    assign RX_BLOCK_O = r_q.rc1[rqhrp_pkg::RC1_BLOCK];
    assign RX_CSUM_EN_O = r_q.rc2[rqhrp_pkg::RC2_CSUM_LSB +: 4];
    assign BUS.rdata = r_q.rdata;
    assign BUS.ack = r_q.ack;
    assign BUS.irq_n = ~(r_q.interrupt_status[rqhrp_pkg::ISR_RX] & r_q.interrupt_enable[rqhrp_pkg::IER_RX]);
endmodule
`default_nettype wire

/* File: src/rqhrp_host.sv */
`default_nettype none
module rqhrp_host (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Device bus
    rqhrp_if.host BUS,
    // Interrupt
    output logic IRQ_O
);
    typedef enum logic [1:0] {PH_IDLE, PH_PAD, PH_DUMMY, PH_MAIN} rqhrp_ph_type;
    typedef struct packed {
        rqhrp_ph_type ph;
        logic [11:0] addr;
        logic wr;
        logic bmode;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [11:0] tally;
        logic dpend;
        logic rdy;
        logic [31:0] prdata;
    } rqhrp_host_type;

    rqhrp_host_type r_q;
    rqhrp_host_type r_d;

    // ------------------------------------------------
    // Next state
    // ------------------------------------------------
    always_comb
    begin
        logic done;
        logic [11:0] step;
        r_d = r_q;
        done = PSEL_I & PENABLE_I & r_q.rdy;
        step = BUS.byte_mode ? 12'h001 : 12'h002;
        r_d.rdy = PSEL_I & PENABLE_I & ~r_q.rdy;
        if (r_d.rdy)
        begin
            unique case (PADDR_I)
                rqhrp_pkg::H_CMD_OFS: r_d.prdata = {18'h0, r_q.bmode, r_q.wr, r_q.addr};
                rqhrp_pkg::H_WDATA_OFS: r_d.prdata = {16'h0000, r_q.wdata};
                rqhrp_pkg::H_RDATA_OFS: r_d.prdata = {16'h0000, r_q.rdata};
                rqhrp_pkg::H_STAT_OFS: r_d.prdata = {30'h0, ~BUS.irq_n, r_q.ph != PH_IDLE};
                default: r_d.prdata = 32'h00000000;
            endcase
        end
        if (done && PWRITE_I)
        begin
            if (PADDR_I == rqhrp_pkg::H_WDATA_OFS)
                r_d.wdata = PWDATA_I[15:0];
            else if (PADDR_I == rqhrp_pkg::H_CMD_OFS && r_q.ph == PH_IDLE)
            begin
                r_d.addr = PWDATA_I[11:0];
                r_d.wr = PWDATA_I[rqhrp_pkg::CMD_WR_BIT];
                r_d.bmode = PWDATA_I[rqhrp_pkg::CMD_BYTE_BIT];
                if (r_d.wr && r_d.addr == rqhrp_pkg::QC_OFS
                    && !r_q.wdata[rqhrp_pkg::QC_START] && r_q.tally[1:0] != 2'h0)
                    r_d.ph = PH_PAD;
                else if (!r_d.wr && r_d.addr == rqhrp_pkg::DATA_OFS && r_q.dpend)
                    r_d.ph = PH_DUMMY;
                else
                    r_d.ph = PH_MAIN;
            end
        end
        if (BUS.ack)
        begin
            unique case (r_q.ph)
                PH_PAD:
                begin
                    r_d.tally = r_q.tally + step;
                    if (r_d.tally[1:0] == 2'h0)
                        r_d.ph = PH_MAIN;
                end
                PH_DUMMY:
                begin
                    r_d.dpend = 1'b0;
                    r_d.ph = PH_MAIN;
                end
                PH_MAIN:
                begin
                    r_d.ph = PH_IDLE;
                    if (!r_q.wr)
                        r_d.rdata = BUS.rdata;
                    if (!r_q.wr && r_q.addr == rqhrp_pkg::DATA_OFS)
                        r_d.tally = r_q.tally + step;
                    if (r_q.wr && r_q.addr == rqhrp_pkg::QC_OFS
                        && r_q.wdata[rqhrp_pkg::QC_START])
                    begin
                        r_d.dpend = 1'b1;
                        r_d.tally = 12'h000;
                    end
                end
                PH_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    // ------------------------------------------------
    // Outputs
    // ------------------------------------------------
    assign PRDATA_O = r_q.prdata;
    assign PREADY_O = r_q.rdy;
    assign PSLVERR_O = 1'b0;
    assign BUS.sel = r_q.ph != PH_IDLE;
    assign BUS.wr = (r_q.ph == PH_MAIN) & r_q.wr;
    assign BUS.addr = (r_q.ph == PH_MAIN) ? r_q.addr : rqhrp_pkg::DATA_OFS;
    assign BUS.wdata = r_q.wdata;
    assign BUS.byte_mode = r_q.bmode | ((r_q.ph == PH_PAD) & r_q.tally[0]);
    assign IRQ_O = ~BUS.irq_n;
endmodule
`default_nettype wire

/* File: testbench/rqhrp_chk.sv */
`default_nettype none
module rqhrp_chk (
    // Clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    // Device bus
    input wire logic sel,
    input wire logic wr,
    input wire logic byte_mode,
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic irq_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ier_q;
    logic start_q;
    logic take;

    assign take = sel && wr && !ack;

    // ------------------------------------------------
    // Shadow of enable bits, updated on the take edge
    // ------------------------------------------------
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            ier_q <= 1'b0;
            start_q <= 1'b0;
        end
        else if (take && addr == rqhrp_pkg::IER_OFS)
        begin
            ier_q <= wdata[rqhrp_pkg::IER_RX];
        end
        else if (take && addr == rqhrp_pkg::QC_OFS)
        begin
            start_q <= wdata[rqhrp_pkg::QC_START];
        end
    end

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RST_N_I);

    // ------------------------------------------------
    // Bus and interrupt checks
    // ------------------------------------------------
    a_ack_follows: assert property (sel && !ack |=> ack)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_req_held: assert property (sel && !ack |=> sel && $stable(addr) && $stable(wr))
        else $error("request changed before ack");
    a_rdata_held: assert property ($changed(rdata) |-> ack && !wr)
        else $error("read data changed outside a read answer");
    a_port_gated: assert property (sel && !wr && !ack && addr == rqhrp_pkg::DATA_OFS
        && !start_q |=> rdata == 16'h0000)
        else $error("data port answered while access closed");
    a_ier_gate: assert property (!ier_q |-> irq_n)
        else $error("interrupt seen while disabled");
    a_w1c_clear: assert property (take && addr == rqhrp_pkg::ISR_OFS
        && wdata[rqhrp_pkg::ISR_RX] |=> irq_n)
        else $error("interrupt stayed after write one clear");
    a_len_width: assert property (sel && !wr && !ack && addr == rqhrp_pkg::HLEN_OFS
        |=> rdata[15:12] == 4'h0)
        else $error("byte count wider than twelve bits");
endmodule
`default_nettype wire

/* File: testbench/tb_rqhrp.sv */
`default_nettype none
module tb_rqhrp;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, psel, pen, pwr, pready, irq, rdy, flow, blk, sof, vld, eof;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] csum;
    logic [15:0] sts, dat;
    logic [11:0] len;
    int n_errors = 0, compares = 0, seed = 97;
    logic [15:0] q_sts[$], q_dat[$];
    logic [11:0] q_len[$];

    rqhrp_if rqhrp_if_i ();
    rqhrp_host rqhrp_host_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(), .BUS(rqhrp_if_i.host), .IRQ_O(irq));
    rqhrp_dev rqhrp_dev_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BUS(rqhrp_if_i.dev),
        .RX_SOF_I(sof), .RX_STS_I(sts), .RX_LEN_I(len), .RX_DAT_VLD_I(vld), .RX_DAT_I(dat),
        .RX_EOF_I(eof), .RX_RDY_O(rdy), .RX_FLOW_EN_O(flow), .RX_BLOCK_O(blk),
        .RX_CSUM_EN_O(csum));
    rqhrp_chk rqhrp_chk_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .sel(rqhrp_if_i.sel),
        .wr(rqhrp_if_i.wr), .byte_mode(rqhrp_if_i.byte_mode), .addr(rqhrp_if_i.addr),
        .wdata(rqhrp_if_i.wdata), .rdata(rqhrp_if_i.rdata), .ack(rqhrp_if_i.ack),
        .irq_n(rqhrp_if_i.irq_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            n_errors++;
        r = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic busy_wait();
        logic [31:0] r;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, rqhrp_pkg::H_STAT_OFS, 32'h00000000, r);
            n++;
        end
        while (r[0] !== 1'b0 && n < 50);
        if (r[0] !== 1'b0)
            n_errors++;
    endtask

    task automatic dwr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        apb(1'b1, rqhrp_pkg::H_WDATA_OFS, {16'h0000, d}, r);
        apb(1'b1, rqhrp_pkg::H_CMD_OFS, {18'h0, 1'b0, 1'b1, a}, r);
        busy_wait();
    endtask

    task automatic drd(input logic [11:0] a, output logic [15:0] d, input logic bm = 1'b0);
        logic [31:0] r;
        apb(1'b1, rqhrp_pkg::H_CMD_OFS, {18'h0, bm, 1'b0, a}, r);
        busy_wait();
        apb(1'b0, rqhrp_pkg::H_RDATA_OFS, 32'h00000000, r);
        d = r[15:0];
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [15:0] e,
        input logic [15:0] m = 16'hFFFF);
        logic [15:0] d;
        drd(a, d);
        chk(nm, {16'h0000, d & m}, {16'h0000, e});
    endtask

    task automatic send(input logic [15:0] s, input logic [11:0] l);
        int n;
        logic [15:0] w;
        n = 0;
        while (rdy !== 1'b1 && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        sof <= 1'b1;
        sts <= s;
        len <= l;
        q_sts.push_back(s);
        q_len.push_back(l);
        repeat ((int'(l) + 1) / 2)
        begin
            @(posedge clk);
            sof <= 1'b0;
            w = 16'($random(seed));
            vld <= 1'b1;
            dat <= w;
            q_dat.push_back(w);
        end
        @(posedge clk);
        sof <= 1'b0;
        vld <= 1'b0;
        eof <= 1'b1;
        @(posedge clk);
        eof <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Open access, read head frame whole, then close and release it
    task automatic drain(input logic bm);
        logic [15:0] w[$];
        logic [15:0] d;
        int nb;
        nb = int'(q_len[0]);
        w.push_back(q_sts.pop_front());
        w.push_back({4'h0, q_len.pop_front()});
        repeat ((nb + 1) / 2) w.push_back(q_dat.pop_front());
        dwr(rqhrp_pkg::DP_OFS, 16'h4000);
        dwr(rqhrp_pkg::QC_OFS, 16'h0038);
        for (int i = 0; i < (bm ? nb + 4 : w.size()); i++)
        begin
            drd(rqhrp_pkg::DATA_OFS, d, bm);
            if (bm)
                chk("port byte", {24'h0, d[7:0]}, {24'h0, w[i / 2][8 * (i % 2) +: 8]});
            else
                chk("port word", {16'h0, d}, {16'h0, w[i]});
        end
        dwr(rqhrp_pkg::QC_OFS, 16'h0030);
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial
    begin
        logic [31:0] r;
        {psel, pen, pwr, paddr, pwdata, sof, vld, eof, sts, len, dat, rst_n} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk("queue control", rqhrp_pkg::QC_OFS, 16'h0000);
        chk("room", {31'h0, rdy}, 32'h1);
        rchk("port closed", rqhrp_pkg::DATA_OFS, 16'h0000);
        apb(1'b0, 8'h10, 32'h00000000, r);
        chk("unmapped", r, 32'h00000000);
        dwr(rqhrp_pkg::RC1_OFS, 16'h0401);
        chk("flow and block", {30'h0, flow, blk}, 32'h00000003);
        for (int i = 0; i < 4; i++)
        begin
            dwr(rqhrp_pkg::RC2_OFS, 16'(1 << i));
            chk("checksum enables", {28'h0, csum}, 32'(1 << i));
        end
        dwr(rqhrp_pkg::FCT_OFS, 16'h0001);
        dwr(rqhrp_pkg::QC_OFS, 16'h0020);
        send(16'($random(seed)), 12'h005);
        rchk("count under", rqhrp_pkg::QC_OFS, 16'h0020);
        send(16'($random(seed)), 12'h007);
        rchk("count over", rqhrp_pkg::QC_OFS, 16'h0420);
        rchk("status set", rqhrp_pkg::ISR_OFS, 16'h2000, 16'h2000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        dwr(rqhrp_pkg::IER_OFS, 16'h2000);
        chk("irq enabled", {31'h0, irq}, 32'h1);
        send(16'($random(seed)), 12'h003);
        rchk("count at irq", rqhrp_pkg::FC_OFS, 16'h0200, 16'hFF00);
        dwr(rqhrp_pkg::ISR_OFS, 16'hFFFF);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rchk("count refreshed", rqhrp_pkg::FC_OFS, 16'h0300, 16'hFF00);
        for (int i = 0; i < 2; i++)
        begin
            rchk("header status", rqhrp_pkg::HSTS_OFS, q_sts[i]);
            rchk("header length", rqhrp_pkg::HLEN_OFS, {4'h0, q_len[i]});
        end
        dwr(rqhrp_pkg::DP_OFS, 16'h0000);
        dwr(rqhrp_pkg::QC_OFS, 16'h0028);
        repeat (2) rchk("no increment", rqhrp_pkg::DATA_OFS, q_sts[0]);
        dwr(rqhrp_pkg::QC_OFS, 16'h0020);
        drain(1'b0);
        rchk("fc read", rqhrp_pkg::FC_OFS, 16'h0000, 16'h0000);
        rchk("head moved", rqhrp_pkg::HSTS_OFS, q_sts[0]);
        drain(1'b1);
        rchk("count dropped", rqhrp_pkg::QC_OFS, 16'h0030);
        drain(1'b0);
        dwr(rqhrp_pkg::ISR_OFS, 16'hFFFF);
        dwr(rqhrp_pkg::DTT_OFS, 16'h0003);
        dwr(rqhrp_pkg::QC_OFS, 16'h0080);
        send(16'($random(seed)), 12'h002);
        repeat (120) @(posedge clk);
        rchk("age under", rqhrp_pkg::QC_OFS, 16'h0000, 16'h1000);
        repeat (450) @(posedge clk);
        rchk("age over", rqhrp_pkg::QC_OFS, 16'h1000, 16'h1000);
        chk("irq age", {31'h0, irq}, 32'h1);
        dwr(rqhrp_pkg::QC_OFS, 16'h0040);
        dwr(rqhrp_pkg::ISR_OFS, 16'hFFFF);
        dwr(rqhrp_pkg::DBT_OFS, 16'h0014);
        rchk("bytes under", rqhrp_pkg::QC_OFS, 16'h0000, 16'h0800);
        chk("irq quiet", {31'h0, irq}, 32'h0);
        send(16'($random(seed)), 12'h028);
        rchk("bytes over", rqhrp_pkg::QC_OFS, 16'h0800, 16'h0800);
        chk("irq bytes", {31'h0, irq}, 32'h1);
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
